// ### core/ccrm_pkg.sv
// package of the clock and reset manager: register map, field positions,
// reset values and writable masks.
// assumes a 32-bit AXI4-Lite bus carrying 16-bit registers in the low half.
package ccrm_pkg;

  // ****************************************************************
  // register indices and byte addresses
  // ****************************************************************
  // printed offsets are halfword spaced, so each is an index and the
  // byte address is four times it
  localparam logic [31:0] SYS_CTRL_IDX = 32'h1500_3800;
  localparam logic [31:0] PAR_CTRL_IDX = 32'h1500_3802;
  localparam logic [31:0] SER_CTRL_IDX = 32'h1500_3804;
  localparam logic [31:0] USB_CTRL_IDX = 32'h1500_380C;
  localparam logic [31:0] KBL_CTRL_IDX = 32'h1500_380E;
  localparam logic [31:0] SYS_CTRL_ADDR = {SYS_CTRL_IDX[29:0], 2'h0};
  localparam logic [31:0] PAR_CTRL_ADDR = {PAR_CTRL_IDX[29:0], 2'h0};
  localparam logic [31:0] SER_CTRL_ADDR = {SER_CTRL_IDX[29:0], 2'h0};
  localparam logic [31:0] USB_CTRL_ADDR = {USB_CTRL_IDX[29:0], 2'h0};
  localparam logic [31:0] KBL_CTRL_ADDR = {KBL_CTRL_IDX[29:0], 2'h0};

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SYS_GLOBAL_INTERNAL_RESET_BIT = 5;
  localparam int SYS_OSC_DIS_BIT = 4;
  localparam int SYS_CKO_DIS_BIT = 0;
  localparam int UNIT_USE_BIT = 2;
  localparam int UNIT_RST_BIT = 1;
  localparam int UNIT_CLK_BIT = 0;
  localparam int KBL_PWM_CLK_BIT = 4;

  // ****************************************************************
  // reset values and writable masks
  // ****************************************************************
  localparam logic [15:0] SYS_CTRL_RST = 16'h0021;
  localparam logic [15:0] PAR_CTRL_RST = 16'h0003;
  localparam logic [15:0] SER_CTRL_RST = 16'h0003;
  localparam logic [15:0] USB_CTRL_RST = 16'h0000;
  localparam logic [15:0] KBL_CTRL_RST = 16'h0013;
  localparam logic [15:0] SYS_CTRL_WMASK = 16'h0031;
  localparam logic [15:0] PAR_CTRL_WMASK = 16'h0007;
  localparam logic [15:0] SER_CTRL_WMASK = 16'h0003;
  localparam logic [15:0] USB_CTRL_WMASK = 16'h0001;
  localparam logic [15:0] KBL_CTRL_WMASK = 16'h0013;

  // ****************************************************************
  // bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CCRM_SEL_NONE,
    CCRM_SEL_SYS,
    CCRM_SEL_PAR,
    CCRM_SEL_SER,
    CCRM_SEL_USB,
    CCRM_SEL_KBL
  } ccrm_sel_e;

endpackage : ccrm_pkg

// ### core/ccrm_clk_gate.sv
// latch based clock gate, idle low or idle high.
// assumes the enable is quasi-static against the gated clock.
`timescale 1ns/10ps
`default_nettype none

module ccrm_clk_gate #(
  parameter logic IDLE_HIGH = 1'b0
) (
  input wire logic clkIn,
  input wire logic enable,
  output logic clkOut
);

  logic enLatch;

  // ****************************************************************
  // gate
  // ****************************************************************
  // the latch is open only in the idle phase, so the output never
  // shows a shortened pulse when the enable moves
  always_latch begin
    if (clkIn == IDLE_HIGH) begin
      enLatch <= enable;
    end
  end

  assign clkOut = IDLE_HIGH ? (clkIn | ~enLatch) : (clkIn & enLatch);

endmodule : ccrm_clk_gate

`default_nettype wire

// ### core/ccrm_clock_reset_manager.sv
// clock and reset manager of the companion chip, with AXI4-Lite registers.
// assumes oscIn is the free running 48 MHz oscillator source and that all
// register logic runs on ref_clk; gated clocks are built from oscIn.
//
// Operation
// - internal reset bit holds other registers reset
// - oscillator disable bit stops system clock low
// - clock output disable holds fast output high
// - system control reset only by external reset
// - reserved bits read zero, written zero
// - parallel bits control unit reset and clock
// - serial bits control unit reset and clock
// - oscillator feeds system and infrared clocks
// - usb clock only while oscillator enabled
`timescale 1ns/10ps
`default_nettype none

module ccrm_clock_reset_manager (
  input wire logic ref_clk,
  input wire logic reset,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // oscillator and clock outputs
  input wire logic oscIn,
  output logic oscillatorEnable,
  output logic systemClock,
  output logic fastClockOutput,
  output logic infraredClock,
  output logic usbHostClock,
  output logic parallelClock,
  output logic serialClock,
  output logic keyboardClock,
  output logic backlightClock,
  // resets and unit status
  output logic globalInternalReset,
  output logic parallelReset,
  output logic serialReset,
  output logic keyboardReset,
  output logic parallelUseEnable
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [15:0] sysCtrl_r;
  logic [15:0] parCtrl_r;
  logic [15:0] serCtrl_r;
  logic [15:0] usb_host_clock_gate_r;
  logic [15:0] kblCtrl_r;

  logic awHeld_r;
  logic wHeld_r;
  logic [31:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;

  logic wrFire;
  logic rdFire;
  ccrm_pkg::ccrm_sel_e wrSel;
  ccrm_pkg::ccrm_sel_e rdSel;
  logic [15:0] laneMask;
  logic global_internal_reset;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic ccrm_pkg::ccrm_sel_e decode(input logic [31:0] addr);
    ccrm_pkg::ccrm_sel_e sel;
    sel = ccrm_pkg::CCRM_SEL_NONE;
    unique case (addr)
      ccrm_pkg::SYS_CTRL_ADDR: sel = ccrm_pkg::CCRM_SEL_SYS;
      ccrm_pkg::PAR_CTRL_ADDR: sel = ccrm_pkg::CCRM_SEL_PAR;
      ccrm_pkg::SER_CTRL_ADDR: sel = ccrm_pkg::CCRM_SEL_SER;
      ccrm_pkg::USB_CTRL_ADDR: sel = ccrm_pkg::CCRM_SEL_USB;
      ccrm_pkg::KBL_CTRL_ADDR: sel = ccrm_pkg::CCRM_SEL_KBL;
      default: sel = ccrm_pkg::CCRM_SEL_NONE;
    endcase
    return sel;
  endfunction : decode

  // merge byte lanes 0 and 1 into a register, keeping reserved bits 0
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [15:0] lanes,
    input logic [15:0] wmask
  );
    logic [15:0] val;
    val = (old & ~lanes) | (data & lanes);
    return val & wmask;
  endfunction : merge

  assign wrSel = decode(awAddr_r);
  assign rdSel = decode(s_axi_araddr);
  assign laneMask = {{8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  assign global_internal_reset = sysCtrl_r[ccrm_pkg::SYS_GLOBAL_INTERNAL_RESET_BIT];

  // ****************************************************************
  // write channels
  // ****************************************************************
  // address and data are taken in either order; the write is done
  // once both are held and the previous response is gone
  assign s_axi_awready = ~awHeld_r;
  assign s_axi_wready = ~wHeld_r;
  assign wrFire = awHeld_r & wHeld_r & ~bValid_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 32'h0000_0000;
    end else if (s_axi_awvalid && !awHeld_r) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else if (s_axi_wvalid && !wHeld_r) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bValid_r <= 1'b0;
      bResp_r <= ccrm_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bValid_r <= 1'b1;
      bResp_r <= (wrSel == ccrm_pkg::CCRM_SEL_NONE) ?
        ccrm_pkg::RESP_SLVERR : ccrm_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  // ****************************************************************
  // system clock control register
  // ****************************************************************
  // only the external reset restores it, never its own reset bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sysCtrl_r <= ccrm_pkg::SYS_CTRL_RST;
    end else if (wrFire && wrSel == ccrm_pkg::CCRM_SEL_SYS) begin
      sysCtrl_r <= merge(sysCtrl_r, wData_r[15:0], laneMask,
        ccrm_pkg::SYS_CTRL_WMASK);
    end
  end

  // ****************************************************************
  // unit control registers
  // ****************************************************************
  // writes during internal reset are accepted on the bus but lost
  always_ff @(posedge ref_clk) begin
    if (reset || global_internal_reset) begin
      parCtrl_r <= ccrm_pkg::PAR_CTRL_RST;
    end else if (wrFire && wrSel == ccrm_pkg::CCRM_SEL_PAR) begin
      parCtrl_r <= merge(parCtrl_r, wData_r[15:0], laneMask,
        ccrm_pkg::PAR_CTRL_WMASK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || global_internal_reset) begin
      serCtrl_r <= ccrm_pkg::SER_CTRL_RST;
    end else if (wrFire && wrSel == ccrm_pkg::CCRM_SEL_SER) begin
      serCtrl_r <= merge(serCtrl_r, wData_r[15:0], laneMask,
        ccrm_pkg::SER_CTRL_WMASK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || global_internal_reset) begin
      usb_host_clock_gate_r <= ccrm_pkg::USB_CTRL_RST;
    end else if (wrFire && wrSel == ccrm_pkg::CCRM_SEL_USB) begin
      usb_host_clock_gate_r <= merge(usb_host_clock_gate_r, wData_r[15:0], laneMask,
        ccrm_pkg::USB_CTRL_WMASK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || global_internal_reset) begin
      kblCtrl_r <= ccrm_pkg::KBL_CTRL_RST;
    end else if (wrFire && wrSel == ccrm_pkg::CCRM_SEL_KBL) begin
      kblCtrl_r <= merge(kblCtrl_r, wData_r[15:0], laneMask,
        ccrm_pkg::KBL_CTRL_WMASK);
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  assign s_axi_arready = ~rValid_r;
  assign rdFire = s_axi_arvalid & ~rValid_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= ccrm_pkg::RESP_OKAY;
    end else if (rdFire) begin
      rValid_r <= 1'b1;
      rResp_r <= ccrm_pkg::RESP_OKAY;
      // upper half and reserved bits read zero
      unique case (rdSel)
        ccrm_pkg::CCRM_SEL_SYS: rData_r <= {16'h0000, sysCtrl_r};
        ccrm_pkg::CCRM_SEL_PAR: rData_r <= {16'h0000, parCtrl_r};
        ccrm_pkg::CCRM_SEL_SER: rData_r <= {16'h0000, serCtrl_r};
        ccrm_pkg::CCRM_SEL_USB: rData_r <= {16'h0000, usb_host_clock_gate_r};
        ccrm_pkg::CCRM_SEL_KBL: rData_r <= {16'h0000, kblCtrl_r};
        ccrm_pkg::CCRM_SEL_NONE: begin
          rData_r <= 32'h0000_0000;
          rResp_r <= ccrm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // ****************************************************************
  // clock enables and resets
  // ****************************************************************
  // enables come from ref_clk flops and are not synchronised to the
  // oscillator; software changes them only with the unit in reset
  logic oscRun_r;
  logic fastOutEn_r;
  logic usbEn_r;
  logic parEn_r;
  logic serEn_r;
  logic kblEn_r;
  logic pwmEn_r;
  logic globalRst_r;
  logic parRst_r;
  logic serRst_r;
  logic kblRst_r;
  logic parUse_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      oscRun_r <= 1'b0;
      fastOutEn_r <= 1'b0;
    end else begin
      oscRun_r <= ~sysCtrl_r[ccrm_pkg::SYS_OSC_DIS_BIT];
      fastOutEn_r <= ~sysCtrl_r[ccrm_pkg::SYS_CKO_DIS_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      usbEn_r <= 1'b0;
      parEn_r <= 1'b0;
      serEn_r <= 1'b0;
      kblEn_r <= 1'b0;
      pwmEn_r <= 1'b0;
    end else begin
      usbEn_r <= ~usb_host_clock_gate_r[ccrm_pkg::UNIT_CLK_BIT] &
        ~sysCtrl_r[ccrm_pkg::SYS_OSC_DIS_BIT];
      parEn_r <= ~parCtrl_r[ccrm_pkg::UNIT_CLK_BIT];
      serEn_r <= ~serCtrl_r[ccrm_pkg::UNIT_CLK_BIT];
      kblEn_r <= ~kblCtrl_r[ccrm_pkg::UNIT_CLK_BIT];
      pwmEn_r <= ~kblCtrl_r[ccrm_pkg::KBL_PWM_CLK_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      globalRst_r <= 1'b1;
      parRst_r <= 1'b1;
      serRst_r <= 1'b1;
      kblRst_r <= 1'b1;
      parUse_r <= 1'b0;
    end else begin
      globalRst_r <= global_internal_reset;
      parRst_r <= parCtrl_r[ccrm_pkg::UNIT_RST_BIT] | global_internal_reset;
      serRst_r <= serCtrl_r[ccrm_pkg::UNIT_RST_BIT] | global_internal_reset;
      kblRst_r <= kblCtrl_r[ccrm_pkg::UNIT_RST_BIT] | global_internal_reset;
      parUse_r <= parCtrl_r[ccrm_pkg::UNIT_USE_BIT];
    end
  end

  assign oscillatorEnable = oscRun_r;
  assign globalInternalReset = globalRst_r;
  assign parallelReset = parRst_r;
  assign serialReset = serRst_r;
  assign keyboardReset = kblRst_r;
  assign parallelUseEnable = parUse_r;

  // ****************************************************************
  // clock gates
  // ****************************************************************
  // the system clock is the root; every unit gate hangs off it, so a
  // stopped oscillator stops all of them
  logic [6:1] gateEn;
  logic [6:1] gateOut;

  assign gateEn = {pwmEn_r, kblEn_r, serEn_r, parEn_r, usbEn_r, 1'b1};

  ccrm_clk_gate #(
    .IDLE_HIGH(1'b0)
  ) u_sys_gate (
    .clkIn(oscIn),
    .enable(oscRun_r),
    .clkOut(systemClock)
  );

  // disable latched on the source's high phase, not the system clock's,
  // so it still takes effect while the oscillator is stopped
  logic fastEnLatch;

  always_latch begin
    if (oscIn) begin
      fastEnLatch <= fastOutEn_r;
    end
  end

  assign fastClockOutput = systemClock | ~fastEnLatch;

  genvar gi;
  generate
    for (gi = 1; gi < 7; gi++) begin : g_unit_gate
      ccrm_clk_gate #(
        .IDLE_HIGH(1'b0)
      ) u_gate (
        .clkIn(systemClock),
        .enable(gateEn[gi]),
        .clkOut(gateOut[gi])
      );
    end
  endgenerate

  assign infraredClock = gateOut[1];
  assign usbHostClock = gateOut[2];
  assign parallelClock = gateOut[3];
  assign serialClock = gateOut[4];
  assign keyboardClock = gateOut[5];
  assign backlightClock = gateOut[6];

endmodule : ccrm_clock_reset_manager

`default_nettype wire

// ### verif/ccrm_monitor.sv
// checker of the clock and reset manager, ports only.
// assumes it is bound to ccrm_clock_reset_manager.
`timescale 1ns/10ps
`default_nettype none

module ccrm_monitor (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic oscillatorEnable,
  input wire logic systemClock,
  input wire logic infraredClock,
  input wire logic usbHostClock,
  input wire logic globalInternalReset,
  input wire logic parallelReset,
  input wire logic serialReset,
  input wire logic keyboardReset
);
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_units_follow_global: assert property (
    globalInternalReset |-> parallelReset && serialReset && keyboardReset)
    else $error("unit reset low under global reset");
  // gates switch in the idle phase, so allow one cycle of settling
  a_sys_clock_stop: assert property (
    !oscillatorEnable && !$past(oscillatorEnable) |-> !systemClock)
    else $error("system clock runs with oscillator off");
  a_ir_clock_stop: assert property (
    !oscillatorEnable && !$past(oscillatorEnable) |-> !infraredClock)
    else $error("infrared clock runs with oscillator off");
  a_usb_clock_stop: assert property (
    !oscillatorEnable && !$past(oscillatorEnable) |-> !usbHostClock)
    else $error("usb clock runs with oscillator off");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp))
    else $error("read answer dropped");
  a_arready_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_release: cover property ($fell(globalInternalReset));
  c_osc_off: cover property ($fell(oscillatorEnable));
endmodule : ccrm_monitor

bind ccrm_clock_reset_manager ccrm_monitor i_mon (.ref_clk, .reset,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .oscillatorEnable, .systemClock, .infraredClock, .usbHostClock,
  .globalInternalReset, .parallelReset, .serialReset, .keyboardReset);
`default_nettype wire

// ### verif/ccrm_unit_model.sv
// peripheral units fed by the gated clocks; each counts its clock edges.
// assumes the clocks come straight from the manager's gates.
`timescale 1ns/10ps
`default_nettype none

module ccrm_unit_model (
  input wire logic [7:0] clks,
  output logic [7:0] edgeCnt [8]
);
  // no reset: a stopped clock could never clear it
  for (genvar g = 0; g < 8; g++) begin : g_unit
    logic [7:0] cnt = 8'h00;
    always_ff @(posedge clks[g]) begin
      cnt <= cnt + 8'h01;
    end
    assign edgeCnt[g] = cnt;
  end
endmodule : ccrm_unit_model
`default_nettype wire

// ### verif/tb.sv
// self-checking bench of the clock and reset manager.
// assumes the manager, its checker and the unit model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam logic [1:0] OK = ccrm_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = ccrm_pkg::RESP_SLVERR;
  localparam logic [15:0] MSK [5] = '{16'h0031, 16'h0007, 16'h0003,
    16'h0001, 16'h0013};
  localparam logic [15:0] RST [5] = '{16'h0021, 16'h0003, 16'h0003,
    16'h0000, 16'h0013};
  localparam logic [31:0] ADR [5] = '{ccrm_pkg::SYS_CTRL_ADDR,
    ccrm_pkg::PAR_CTRL_ADDR, ccrm_pkg::SER_CTRL_ADDR,
    ccrm_pkg::USB_CTRL_ADDR, ccrm_pkg::KBL_CTRL_ADDR};
  logic ref_clk = 1'b0;
  logic oscIn = 1'b0;
  logic reset = 1'b1;
  logic [31:0] awAddr = '0, wData = '0, arAddr = '0, rData;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic [3:0] wStrb = 4'hF;
  logic arValid = 1'b0, rReady = 1'b0;
  logic [1:0] bResp, rResp;
  logic awReady, wReady, bValid, arReady, rValid, oscillator_disable, sysClk, fastClk;
  logic irClk, usb_host_clock_stop, parClk, serClk, kbClk, blClk;
  logic gRst, parRst, serRst, kbRst, parUse;
  logic [7:0] cnt [8];
  logic [15:0] regV [5];
  int numErrors = 0;
  int numChecks = 0;

  always #25 ref_clk = ~ref_clk;
  always #10.417 oscIn = ~oscIn;

  ccrm_clock_reset_manager i_dut (.ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .oscIn(oscIn),
    .oscillatorEnable(oscillator_disable), .systemClock(sysClk),
    .fastClockOutput(fastClk), .infraredClock(irClk), .usbHostClock(usb_host_clock_stop),
    .parallelClock(parClk), .serialClock(serClk), .keyboardClock(kbClk),
    .backlightClock(blClk), .globalInternalReset(gRst),
    .parallelReset(parRst), .serialReset(serRst), .keyboardReset(kbRst),
    .parallelUseEnable(parUse));

  ccrm_unit_model i_units (.clks({blClk, kbClk, fastClk, sysClk, irClk,
    usb_host_clock_stop, serClk, parClk}), .edgeCnt(cnt));

  // ****************
  // checks and bus cycles
  // ****************
  task automatic chk(input string what, input logic [31:0] seen, exp);
    numChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    if (numErrors == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge ref_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid);
    bReady <= 1'b0;
    chk("bresp", 32'(bResp), 32'(er));
  endtask : wr

  task automatic rdc(input logic [31:0] a, ed, input logic [1:0] er);
    @(posedge ref_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arReady) arValid <= 1'b0;
    end while (!rValid);
    rReady <= 1'b0;
    chk("rdata", rData, ed);
    chk("rresp", 32'(rResp), 32'(er));
  endtask : rdc

  // the expected register image follows every write
  task automatic wreg(input int k, input logic [15:0] v);
    wr(ADR[k], {16'h0000, v}, OK);
    if (k == 0) begin
      regV[0] = v & MSK[0];
      if (v[5]) for (int i = 1; i < 5; i++) regV[i] = RST[i];
    end else if (!regV[0][5]) begin
      regV[k] = v & MSK[k];
    end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : wreg

  task automatic rdk(input int k);
    rdc(ADR[k], {16'h0000, regV[k]}, OK);
  endtask : rdk

  function automatic logic [7:0] expAct();
    logic osc;
    osc = !regV[0][4];
    return {osc & !regV[4][4], osc & !regV[4][0], osc & !regV[0][0], osc,
      osc, osc & !regV[3][0], osc & !regV[2][0], osc & !regV[1][0]};
  endfunction : expAct

  task automatic act(input logic [7:0] e);
    logic [7:0] s [8];
    s = cnt;
    repeat (10) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      chk($sformatf("clock %0d activity", i), 32'(cnt[i] != s[i]),
        32'(e[i]));
    end
  endtask : act

  // ****************
  // scenarios
  // ****************
  initial begin
    logic [15:0] d;
    void'($urandom(32'h33A3));
    regV = RST;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    for (int k = 0; k < 5; k++) rdk(k);
    chk("global reset", 32'(gRst), 32'h1);
    chk("unit resets", 32'({parRst, serRst, kbRst}), 32'h7);
    chk("fast idle", 32'(fastClk), 32'h1);
    act(expAct());
    wr(ADR[1], 32'h0006, OK);
    rdk(1);
    wreg(0, 16'h0001);
    chk("global released", 32'(gRst), 32'h0);
    chk("own reset kept", 32'(parRst), 32'h1);
    wreg(1, 16'h0006);
    rdk(1);
    chk("use enable", 32'(parUse), 32'h1);
    act(expAct());
    repeat (20) @(posedge ref_clk);
    wreg(1, 16'h0004);
    chk("parallel released", 32'(parRst), 32'h0);
    wreg(2, 16'h0002);
    chk("serial held", 32'(serRst), 32'h1);
    // the long serial wait is cut short to keep the run brief
    repeat (200) @(posedge ref_clk);
    wreg(2, 16'h0000);
    chk("serial released", 32'(serRst), 32'h0);
    repeat (6) begin
      d = 16'($urandom());
      wreg(2, d & 16'h0003);
      wreg(1, ((d >> 2) & 16'h0003) | 16'h0004);
      wreg(3, (d >> 4) & 16'h0001);
      wreg(4, (d >> 5) & 16'h0013);
      for (int k = 1; k < 4; k++) rdk(k);
      chk("serial reset", 32'(serRst), 32'(regV[2][1]));
      chk("parallel reset", 32'(parRst), 32'(regV[1][1]));
      chk("keyboard reset", 32'(kbRst), 32'(regV[4][1]));
      act(expAct());
    end
    wr(ADR[3], 32'h0000FFFF, OK);
    regV[3] = 16'h0001;
    rdk(3);
    wStrb <= 4'hE;
    wr(ADR[3], 32'h00000000, OK);
    rdk(3);
    wStrb <= 4'hF;
    wr(ADR[0] + 32'h4, 32'h0000FFFF, ERR);
    rdc(ADR[0] + 32'h4, 32'h0, ERR);
    wreg(3, 16'h0000);
    wreg(0, 16'h0021);
    wreg(0, 16'h0031);
    chk("oscillator off", 32'(oscillator_disable), 32'h0);
    rdk(0);
    rdk(1);
    act(expAct());
    chk("fast held high", 32'(fastClk), 32'h1);
    wreg(0, 16'h0030);
    chk("fast low with osc off", 32'(fastClk), 32'h0);
    wreg(0, 16'h0020);
    wreg(0, 16'h0000);
    act(expAct());
    reset <= 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    regV = RST;
    for (int k = 0; k < 5; k++) rdk(k);
    act(expAct());
    close_out();
  end

  initial begin
    #(50 * 20000);
    chk("watchdog", 32'h1, 32'h0);
    close_out();
  end
endmodule : tb
`default_nettype wire
